// ==== core/ppt_consts.vh ====
// Constants for the paired period timer: offsets, fields, reset values
`ifndef PPT_CONSTS_VH
`define PPT_CONSTS_VH

// Register word offsets (byte addresses), per pair: base = pair * 0x20
`define PPT_OFF_CTRL_LO   5'h00
`define PPT_OFF_CTRL_HI   5'h04
`define PPT_OFF_PER_LO    5'h08
`define PPT_OFF_PER_HI    5'h0c
`define PPT_OFF_CNT_LO    5'h10
`define PPT_OFF_CNT_HI    5'h14
`define PPT_OFF_FLAGS     5'h18
`define PPT_OFF_SYS       5'h1c
`define PPT_OFF_NONE      5'h1f
`define PPT_PAIR_MSB      6
`define PPT_PAIR_LSB      5

// Control register field positions
`define PPT_B_ON          15
`define PPT_B_HALT_IDLE   13
`define PPT_B_GATE        6
`define PPT_B_PS_HI       5
`define PPT_B_PS_LO       4
`define PPT_B_WIDE        3
`define PPT_B_CLKSRC      1
`define PPT_CTRL_MASK_LO  16'ha07a
`define PPT_CTRL_MASK_HI  16'ha072

// Reset values
`define PPT_CTRL_RST      16'h0000
`define PPT_PER_RST       16'hffff
`define PPT_CNT_RST       16'h0000

// Prescale ratios minus one
`define PPT_DIV1_M1       8'h00
`define PPT_DIV8_M1       8'h07
`define PPT_DIV64_M1      8'h3f
`define PPT_DIV256_M1     8'hff

`endif

// ==== core/ppt_timer.v ====
// Paired period timer: four pairs of 16-bit timers behind Wishbone
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// Functional notes
// - Each pair runs as one 32-bit timer or two 16-bit timers.
// - Split halves support all 16-bit modes except asynchronous counting.
// - Combined pair runs as a 32-bit timer or synchronous counter.
// - Each lone 16-bit timer is a synchronous timer or counter.
// - Lower timer holds the low word, upper timer the high word.
// - In 32-bit mode upper control bits are ignored.
// - Wide mode uses lower clock and gate; flags upper interrupt.
// - Wide period: upper period register high word, lower low word.
// - Wide count readable as pair: upper high word, lower low word.
// - Interrupt when 32-bit count matches the 32-bit period.
// - Wide select bit in lower control joins the pair.
// - Count enable starts and stops the timer or the whole pair.
// - Prescale code 11=256, 10=64, 01=8, 00=1; lower field in wide.
// - Gate bit counts only while gate active; ignored on external clock.
// - Clock source selects external pin rising edge or internal clock.
// - Timers can keep running in idle mode.
// - Only the first pair feeds capture and compare time bases.
// - First pair triggers the first ADC, second pair the second.
// - Only the two timers of the first pair raise DMA triggers.

`include "ppt_consts.vh"

module ppt_timer
(
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Power modes
  input  wire        idleMode,
  // Pins: external count clock and gate, one per 16-bit timer
  input  wire [7:0]  externalCountPin,
  input  wire [7:0]  gateIn,
  // Event outputs
  output reg  [7:0]  matchEvent,
  output reg  [15:0] captureBaseLo,
  output reg  [15:0] captureBaseHi,
  output reg         adc1Trigger,
  output reg         adc2Trigger,
  output reg  [1:0]  dmaTrigger
);

  // ---------------------------------------------------------------
  // Pin synchronisers and count-pin edge detect
  // ---------------------------------------------------------------
  reg [7:0] extMeta_q;
  reg [7:0] extSync_q;
  reg [7:0] extPrev_q;
  reg [7:0] gateMeta_q;
  reg [7:0] gateSync_q;

  // Two flops before any logic; edge detect compares the second with a third
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      extMeta_q  <= 8'h00;
      extSync_q  <= 8'h00;
      extPrev_q  <= 8'h00;
      gateMeta_q <= 8'h00;
      gateSync_q <= 8'h00;
    end
    else
    begin
      extMeta_q  <= externalCountPin;
      extSync_q  <= extMeta_q;
      extPrev_q  <= extSync_q;
      gateMeta_q <= gateIn;
      gateSync_q <= gateMeta_q;
    end
  end

  // Rising edges of the synchronised count pins
  wire [7:0] extRise = extSync_q & ~extPrev_q;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [15:0] ctrl_q   [0:7];
  reg [15:0] period_q [0:7];
  reg [15:0] count_q  [0:7];
  reg [7:0]  presc_q  [0:7];
  reg [7:0]  flag_q;

  // Wishbone decode
  wire       busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       busWr    = busReq & wb_we_i;
  wire [1:0] pairSel  = wb_adr_i[`PPT_PAIR_MSB:`PPT_PAIR_LSB];
  // Addresses past the last pair decode to no register, so no alias
  wire [4:0] regOff   = wb_adr_i[7] ? `PPT_OFF_NONE : wb_adr_i[4:0];
  wire [2:0] loIdx    = {pairSel, 1'b0};
  wire [2:0] hiIdx    = {pairSel, 1'b1};
  wire       wrLoByte = busWr & wb_sel_i[0];
  wire       wrHiByte = busWr & wb_sel_i[1];

  // Per-timer tick, match and effective control
  reg  [7:0] tick;
  reg  [7:0] match;
  reg  [7:0] wrap;
  reg  [7:0] effOn;
  reg  [7:0] wideOf;
  reg  [7:0] haltNow;
  reg  [7:0] srcEvent;
  reg  [7:0] divM1 [0:7];

  // Loop indices, one set per process so each has a single driver
  integer    kw;
  integer    lw;
  integer    kc;
  integer    lc;
  integer    ks;
  integer    ko;

  // ---------------------------------------------------------------
  // Pair view: mode and idle halt as each half sees them
  // ---------------------------------------------------------------

  // Both halves follow the wide bit held in the lower control word
  always @*
  begin
    lw = 0;
    for (kw = 0; kw < 8; kw = kw + 1)
    begin
      lw = kw & 6;
      wideOf[kw] = ctrl_q[lw][`PPT_B_WIDE];
      // A joined pair obeys the lower halt bit, split halves their own
      if (wideOf[kw])
        haltNow[kw] = idleMode & ctrl_q[lw][`PPT_B_HALT_IDLE];
      else
        haltNow[kw] = idleMode & ctrl_q[kw][`PPT_B_HALT_IDLE];
    end
  end

  // ---------------------------------------------------------------
  // Count clock, prescale and period match
  // ---------------------------------------------------------------

  // Effective control per half: wide pair takes lower bits only
  always @*
  begin
    lc = 0;
    for (kc = 0; kc < 8; kc = kc + 1)
    begin
      lc = kc & 6;
      // Upper half idles in wide mode; lower drives both words
      if (wideOf[kc])
        effOn[kc] = (kc == lc) & ctrl_q[lc][`PPT_B_ON];
      else
        effOn[kc] = ctrl_q[kc][`PPT_B_ON];
      // Idle stops a timer only when its halt bit asks for it
      effOn[kc] = effOn[kc] & ~haltNow[kc];
      // Internal clock is every cycle, gated when asked; pin otherwise
      if (ctrl_q[kc][`PPT_B_CLKSRC])
        srcEvent[kc] = extRise[kc];
      else if (ctrl_q[kc][`PPT_B_GATE])
        srcEvent[kc] = gateSync_q[kc];
      else
        srcEvent[kc] = 1'b1;
      case (ctrl_q[kc][`PPT_B_PS_HI:`PPT_B_PS_LO])
        2'b11:   divM1[kc] = `PPT_DIV256_M1;
        2'b10:   divM1[kc] = `PPT_DIV64_M1;
        2'b01:   divM1[kc] = `PPT_DIV8_M1;
        default: divM1[kc] = `PPT_DIV1_M1;
      endcase
      // Tick on the last source event of each prescale round
      tick[kc] = effOn[kc] & srcEvent[kc] & (presc_q[kc] == divM1[kc]);
    end
    // Match: 16-bit per half, or the full 32-bit value of the pair
    for (kc = 0; kc < 8; kc = kc + 1)
    begin
      lc = kc & 6;
      if (wideOf[kc])
        match[kc] = ({count_q[lc + 1], count_q[lc]} ==
                     {period_q[lc + 1], period_q[lc]});
      else
        match[kc] = (count_q[kc] == period_q[kc]);
      // A wide pair wraps both words on the lower half's tick
      if (wideOf[kc])
        wrap[kc] = tick[lc] & match[kc];
      else
        wrap[kc] = tick[kc] & match[kc];
    end
  end

  // ---------------------------------------------------------------
  // Counters, prescalers, flags and bus writes
  // ---------------------------------------------------------------

  // Counting and bus writes share one process, so a register write beats the count update; a flag set beats its clear
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (ks = 0; ks < 8; ks = ks + 1)
      begin
        ctrl_q[ks]   <= `PPT_CTRL_RST;
        period_q[ks] <= `PPT_PER_RST;
        count_q[ks]  <= `PPT_CNT_RST;
        presc_q[ks]  <= 8'h00;
      end
      flag_q <= 8'h00;
    end
    else
    begin
      for (ks = 0; ks < 8; ks = ks + 1)
      begin
        // Prescaler advances on each selected source event
        if (!effOn[ks])
          presc_q[ks] <= 8'h00;
        else if (srcEvent[ks])
          presc_q[ks] <= (presc_q[ks] == divM1[ks]) ? 8'h00 :
                         presc_q[ks] + 8'h01;
        if (wideOf[ks])
        begin
          // Lower tick clocks both words synchronously
          if (tick[ks & 6])
          begin
            if (wrap[ks])
              count_q[ks] <= 16'h0000;
            else if ((ks & 1) == 0)
              count_q[ks] <= count_q[ks] + 16'h0001;
            else if (count_q[ks & 6] == 16'hffff)
              count_q[ks] <= count_q[ks] + 16'h0001;
          end
        end
        else if (tick[ks])
          count_q[ks] <= wrap[ks] ? 16'h0000 :
                         count_q[ks] + 16'h0001;
      end
      // Sticky flags; the wide pair reports on the upper flag
      for (ks = 0; ks < 8; ks = ks + 1)
      begin
        if (wideOf[ks] ? ((ks & 1) == 1) & wrap[ks] : wrap[ks])
          flag_q[ks] <= 1'b1;
        else if (busWr && regOff == `PPT_OFF_FLAGS && wb_sel_i[0] &&
                 pairSel == ks[2:1] && wb_dat_i[ks & 1])
          flag_q[ks] <= 1'b0; // write one to clear, set wins
      end
      // Register writes; bus write overrides the counter's update
      if (busWr)
      begin
        if (regOff == `PPT_OFF_CTRL_LO)
        begin
          if (wrLoByte)
            ctrl_q[loIdx][7:0] <= wb_dat_i[7:0] &
                                  8'h7a;
          if (wrHiByte)
            ctrl_q[loIdx][15:8] <= wb_dat_i[15:8] &
                                   8'ha0;
        end
        else if (regOff == `PPT_OFF_CTRL_HI)
        begin
          if (wrLoByte)
            ctrl_q[hiIdx][7:0] <= wb_dat_i[7:0] & 8'h72;
          if (wrHiByte)
            ctrl_q[hiIdx][15:8] <= wb_dat_i[15:8] & 8'ha0;
        end
        else if (regOff == `PPT_OFF_PER_LO)
        begin
          if (wrLoByte) period_q[loIdx][7:0]  <= wb_dat_i[7:0];
          if (wrHiByte) period_q[loIdx][15:8] <= wb_dat_i[15:8];
        end
        else if (regOff == `PPT_OFF_PER_HI)
        begin
          if (wrLoByte) period_q[hiIdx][7:0]  <= wb_dat_i[7:0];
          if (wrHiByte) period_q[hiIdx][15:8] <= wb_dat_i[15:8];
        end
        else if (regOff == `PPT_OFF_CNT_LO)
        begin
          if (wrLoByte) count_q[loIdx][7:0]  <= wb_dat_i[7:0];
          if (wrHiByte) count_q[loIdx][15:8] <= wb_dat_i[15:8];
        end
        else if (regOff == `PPT_OFF_CNT_HI)
        begin
          if (wrLoByte) count_q[hiIdx][7:0]  <= wb_dat_i[7:0];
          if (wrHiByte) count_q[hiIdx][15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus reads and answer; one wait-free ack per request
  // ---------------------------------------------------------------
  reg [31:0] rdData;

  // Unmapped offsets read zero and still acknowledge
  always @*
  begin
    rdData = 32'h0000_0000;
    if (regOff == `PPT_OFF_CTRL_LO)
      rdData[15:0] = ctrl_q[loIdx];
    else if (regOff == `PPT_OFF_CTRL_HI)
      rdData[15:0] = ctrl_q[hiIdx];
    else if (regOff == `PPT_OFF_PER_LO)
      rdData[15:0] = period_q[loIdx];
    else if (regOff == `PPT_OFF_PER_HI)
      rdData[15:0] = period_q[hiIdx];
    else if (regOff == `PPT_OFF_CNT_LO)
      rdData[15:0] = count_q[loIdx];
    else if (regOff == `PPT_OFF_CNT_HI)
      rdData[15:0] = count_q[hiIdx];
    else if (regOff == `PPT_OFF_FLAGS)
      rdData[1:0] = {flag_q[hiIdx], flag_q[loIdx]};
    else if (regOff == `PPT_OFF_SYS)
      rdData[0] = ctrl_q[loIdx][`PPT_B_WIDE];
  end

  // Registered answer and event outputs
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h0000_0000;
      matchEvent    <= 8'h00;
      captureBaseLo <= 16'h0000;
      captureBaseHi <= 16'h0000;
      adc1Trigger   <= 1'b0;
      adc2Trigger   <= 1'b0;
      dmaTrigger    <= 2'b00;
    end
    else
    begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? rdData : 32'h0000_0000;
      // Wide match pulses on the upper timer's event only
      for (ko = 0; ko < 8; ko = ko + 1)
        matchEvent[ko] <= wideOf[ko] ?
                          ((ko & 1) == 1) & wrap[ko] : wrap[ko];
      captureBaseLo <= count_q[0];
      captureBaseHi <= count_q[1];
      adc1Trigger   <= wrap[0] | wrap[1];
      adc2Trigger   <= wrap[2] | wrap[3];
      // In wide mode the lower half never wraps alone, so bit 0 rests
      dmaTrigger    <= {wrap[1],
                        wideOf[0] ? 1'b0 : wrap[0]};
    end
  end

endmodule

// ==== verification/ppt_timer_assertions.sv ====
// Bus handshake and event output checks for the paired period timer
`timescale 1ns/1ps
module ppt_timer_assertions
(
  // Clock and reset
  input wire        core_clk,
  input wire        rst_b,
  // Bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // Events
  input wire [7:0]  matchEvent,
  input wire        adc1Trigger,
  input wire        adc2Trigger,
  input wire [1:0]  dmaTrigger
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Taken request, then a single-cycle answer
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_ackOnce;
    s_take |=> s_ackPulse;
  endproperty
  property p_ackCause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  property p_datIdle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  // Nothing stirs at the first edge out of reset
  property p_quietStart;
    $rose(rst_b) |-> matchEvent == 8'h00 && !wb_ack_o;
  endproperty
  // Triggers only come with a wrap of their own pair
  property p_adc1;
    adc1Trigger |-> |matchEvent[1:0];
  endproperty
  property p_adc2;
    adc2Trigger |-> |matchEvent[3:2];
  endproperty
  property p_dma0;
    dmaTrigger[0] |-> matchEvent[0];
  endproperty
  property p_dma1;
    dmaTrigger[1] |-> matchEvent[1];
  endproperty

  a_ackOnce: assert property (p_ackOnce) else $error("ack not one cycle");
  a_ackCause: assert property (p_ackCause) else $error("ack without cycle");
  a_datIdle: assert property (p_datIdle) else $error("data outside ack");
  a_quietStart: assert property (p_quietStart) else $error("busy at reset");
  a_adc1: assert property (p_adc1) else $error("stray adc1 trigger");
  a_adc2: assert property (p_adc2) else $error("stray adc2 trigger");
  a_dma0: assert property (p_dma0) else $error("stray dma0 trigger");
  a_dma1: assert property (p_dma1) else $error("stray dma1 trigger");
endmodule

bind ppt_timer ppt_timer_assertions ppt_timer_assertions_i (
  .core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .matchEvent(matchEvent), .adc1Trigger(adc1Trigger),
  .adc2Trigger(adc2Trigger), .dmaTrigger(dmaTrigger));

// ==== verification/testbench.sv ====
// Self-checking bench for the paired period timer
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  reg         core_clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         cyc = 1'b0;
  reg         we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] datW = 32'h0;
  reg         idle = 1'b0;
  reg  [7:0]  extPin = 8'h00;
  reg  [7:0]  gate = 8'h00;
  wire [31:0] datR;
  wire        ack;
  wire [7:0]  match;
  wire [15:0] capLo;
  integer     err_count = 0;
  integer     compares = 0;
  integer     cycles = 0;
  integer     gap;
  integer     i;
  reg  [31:0] rd;

  always #5 core_clk = ~core_clk;

  ppt_timer ppt_timer_i (.core_clk(core_clk), .rst_b(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
    .idleMode(idle), .externalCountPin(extPin), .gateIn(gate),
    .matchEvent(match), .captureBaseLo(capLo), .captureBaseHi(),
    .adc1Trigger(), .adc2Trigger(), .dmaTrigger());

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task end_of_test;
  begin
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  // Held until the edge that samples ack high, released at that edge
  task wb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge core_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    @(posedge core_clk);
    while (ack !== 1'b1)
      @(posedge core_clk);
    rd = datR;
    cyc <= 1'b0;
  end
  endtask

  // Cycles between edges of a wrap pulse, less one
  task waitEv(input integer b, output integer n);
  begin
    n = 0;
    @(posedge core_clk);
    #1;
    while (match[b] !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk);
      #1;
      n = n + 1;
    end
  end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task testRegs;
  begin
    wb(0, 8'h00, 0); chk(rd, 32'h0);
    wb(0, 8'h08, 0); chk(rd, 32'hffff);
    wb(0, 8'h10, 0); chk(rd, 32'h0);
    wb(1, 8'h00, 32'hffff); wb(0, 8'h00, 0); chk(rd, 32'ha07a);
    wb(1, 8'h04, 32'hffff); wb(0, 8'h04, 0); chk(rd, 32'ha072);
    wb(1, 8'h80, 32'hffff); wb(0, 8'h80, 0); chk(rd, 32'h0);
    wb(1, 8'h00, 0);
    wb(1, 8'h04, 0);
    $display("register test done");
  end
  endtask

  task testPrescale;
  begin
    wb(1, 8'h08, 3);
    wb(1, 8'h0c, 3);
    wb(1, 8'h04, 32'h8000);
    // Every prescale code, period 3 gives four ticks a wrap
    for (i = 0; i < 4; i = i + 1)
    begin
      wb(1, 8'h00, 32'h8000 | (i << 4));
      waitEv(0, gap);
      waitEv(0, gap);
      chk(gap, 4 * (i == 3 ? 256 : i == 2 ? 64 : i == 1 ? 8 : 1) - 1);
    end
    waitEv(1, gap);
    waitEv(1, gap);
    chk(gap, 3);
    wb(1, 8'h00, 0);
    wb(0, 8'h10, 0);
    gap = rd;
    repeat (20) @(posedge core_clk);
    wb(0, 8'h10, 0); chk(rd, gap);
    chk(capLo, gap);
    $display("prescale test done");
  end
  endtask

  task testSources;
  begin
    wb(1, 8'h08, 32'hffff);
    wb(1, 8'h10, 0);
    wb(1, 8'h00, 32'h8040);
    repeat (20) @(posedge core_clk);
    wb(0, 8'h10, 0); chk(rd, 32'h0);
    gate <= 8'h01;
    repeat (10) @(posedge core_clk);
    wb(0, 8'h10, 0); chk(rd == 0, 0);
    gate <= 8'h00;
    // Gate bit set but external source: five rising edges
    wb(1, 8'h00, 32'h8042);
    wb(1, 8'h10, 0);
    repeat (10)
    begin
      @(posedge core_clk);
      extPin <= ~extPin;
      repeat (3) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    wb(0, 8'h10, 0); chk(rd, 32'h5);
    idle <= 1'b1;
    wb(1, 8'h00, 32'ha000);
    wb(1, 8'h10, 0);
    repeat (20) @(posedge core_clk);
    wb(0, 8'h10, 0); chk(rd, 32'h0);
    wb(1, 8'h00, 32'h8000);
    repeat (20) @(posedge core_clk);
    wb(0, 8'h10, 0); chk(rd == 0, 0);
    idle <= 1'b0;
    wb(1, 8'h00, 0);
    $display("source test done");
  end
  endtask

  // Pair one joined; its upper control asks for a slow prescale
  task testWide;
  begin
    wb(1, 8'h20, 32'h0008);
    wb(1, 8'h24, 32'h0030);
    wb(1, 8'h28, 32'hffff);
    wb(1, 8'h2c, 1);
    wb(1, 8'h30, 32'hfff0);
    wb(1, 8'h20, 32'h8008);
    repeat (40) @(posedge core_clk);
    wb(0, 8'h34, 0); chk(rd, 32'h1);
    wb(0, 8'h3c, 0); chk(rd, 32'h1);
    wb(1, 8'h20, 0);
    wb(1, 8'h28, 5);
    wb(1, 8'h2c, 0);
    wb(1, 8'h30, 0);
    wb(1, 8'h34, 0);
    wb(1, 8'h20, 32'h8008);
    waitEv(3, gap);
    waitEv(3, gap);
    chk(gap, 5);
    wb(1, 8'h20, 0);
    $display("wide test done");
  end
  endtask

  // ----------------------------------------
  // Sequence and hang guard
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    testRegs;
    testPrescale;
    testSources;
    testWide;
    end_of_test;
  end

  // A stuck wait would otherwise never end the run
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      err_count = err_count + 1;
      end_of_test;
    end
  end
endmodule
